// ===== hw/sar_adc_serial_readout.sv
// serial result readout of a sampling converter: trigger, serial clock, data out
// assumes sck and conversion_trigger are synchronous to clock and much slower;
// converter words arrive as straight binary on the sample port
`timescale 1ns/1ps
module sar_adc_serial_readout #(
    parameter int RESOLUTION = adc_readout_pkg::RESOLUTION_DEFAULT,
    parameter int BUFFER_DEPTH = adc_readout_pkg::BUFFER_DEPTH_DEFAULT
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sck,
    input wire logic conversion_trigger,
    input wire logic sample_valid,
    input wire logic [RESOLUTION-1:0] sample_data,
    output logic sample_ready,
    output logic sdo_out,
    output logic sdo_oe,
    output logic frame_busy,
    output logic nap_mode,
    output logic sleep_mode,
    output logic word_missed
);
    localparam int W = adc_readout_pkg::EDGE_COUNT_W;
    localparam logic [W-1:0] FIRST_EDGE = W'(adc_readout_pkg::FIRST_BIT_EDGE);
    localparam logic [W-1:0] LAST_EDGE = W'(adc_readout_pkg::FIRST_BIT_EDGE + RESOLUTION - 1);
    localparam logic [W-1:0] FRAME_END = W'(adc_readout_pkg::FRAME_EDGES);

    // pin edge detectors
    logic sck_prev_reg;
    logic trigger_prev_reg;
    wire sck_rise = sck && !sck_prev_reg;
    wire trigger_rise = conversion_trigger && !trigger_prev_reg;

    // frame control
    adc_readout_pkg::frame_state_t state_reg;
    adc_readout_pkg::frame_state_t state_next;
    logic [W-1:0] edge_count_reg;
    logic [W-1:0] edge_count_next;
    logic [RESOLUTION-1:0] shift_reg;
    logic [RESOLUTION-1:0] shift_next;

    // output flops
    logic sdo_out_reg;
    logic sdo_out_next;
    logic sdo_oe_reg;
    logic sdo_oe_next;
    logic frame_busy_reg;
    logic nap_mode_reg;
    logic sleep_mode_reg;
    logic word_missed_reg;
    logic sample_ready_reg;
    logic buffer_ready;

    // power state from the mode controller
    adc_readout_pkg::power_mode_t mode;
    logic [2:0] trigger_run;

    // converted words on their way to the shifter
    sample_if #(.WIDTH(RESOLUTION)) words ();

    // the buffer absorbs words that arrive while a frame is still shifting
    result_buffer #(
        .WIDTH(RESOLUTION),
        .DEPTH(BUFFER_DEPTH)
    ) u_buffer (
        .clock(clock),
        .nrst(nrst),
        .in_valid(sample_valid),
        .in_data(sample_data),
        .in_ready(buffer_ready),
        .out(words.source)
    );

    power_mode_ctrl u_power (
        .clock(clock),
        .nrst(nrst),
        .trigger_rise(trigger_rise),
        .sck_rise(sck_rise),
        .mode(mode),
        .trigger_run(trigger_run)
    );

    // straight binary to two's complement is a flip of the top bit
    function automatic logic [RESOLUTION-1:0] to_twos(input logic [RESOLUTION-1:0] code);
        to_twos = {~code[RESOLUTION-1], code[RESOLUTION-2:0]};
    endfunction

    // true when a given edge count falls inside the result bits
    function automatic logic in_data_window(input logic [W-1:0] n);
        in_data_window = (n >= FIRST_EDGE) && (n <= LAST_EDGE);
    endfunction

    // trigger classification
    // the first rise since a serial clock rise may start a frame; a second one
    // means the host asks for nap, so the running frame is dropped
    wire first_trigger = trigger_rise && (sck_rise || trigger_run == 3'h0);
    wire awake = (mode == adc_readout_pkg::MODE_ACTIVE) || sck_rise;
    wire running = (state_reg == adc_readout_pkg::frame_state_t'(adc_readout_pkg::FRAME_RUN));
    wire locked = running && (edge_count_reg < FRAME_END); // [R12]
    wire start = first_trigger && awake && !locked; // [R12]
    wire abort = trigger_rise && !first_trigger; // [R13]

    // the shifter takes a word only at the start of a frame
    assign words.ready = start;
    wire word_taken = start && words.valid;

    // per-edge decodes shared by the counter, the shifter and the pin
    wire sck_in_frame = running && sck_rise; // [R01]
    wire frame_done = (edge_count_reg == adc_readout_pkg::EDGE_COUNT_DONE);
    wire window_next = in_data_window(edge_count_next); // [R11]
    wire release_now = abort || start; // [R08]

    // edge counter since the accepted trigger, saturating past the frame
    // edges 1 and 2 keep the pin released while the converter settles, then the
    // word goes out, and edge 16 unlocks the trigger for the next frame
    wire [W-1:0] count_step = frame_done ? edge_count_reg : edge_count_reg + 1'b1;

    // frame state and counter next values
    always_comb
    begin
        state_next = state_reg;
        edge_count_next = edge_count_reg;
        if (start)
        begin
            state_next = adc_readout_pkg::FRAME_RUN; // [R12]
            edge_count_next = '0;
            if (sck_rise)
                edge_count_next = W'(1); // [R11]
        end
        else if (abort)
        begin
            state_next = adc_readout_pkg::FRAME_IDLE; // [R13]
            edge_count_next = '0;
        end
        else if (sck_in_frame)
        begin
            edge_count_next = count_step; // [R01] [R11]
            if (frame_done)
                state_next = adc_readout_pkg::FRAME_IDLE;
        end
    end

    // shifter: load at start, move one bit per serial clock rise in the window
    // if the buffer is empty the leftover shift contents, zeros after a full frame, are sent and flagged
    always_comb
    begin
        shift_next = shift_reg;
        if (start && words.valid)
            shift_next = to_twos(words.data); // [R07]
        else if (sck_in_frame && window_next)
            shift_next = {shift_reg[RESOLUTION-2:0], 1'b0}; // [R01] [R02]
    end

    // serial output next value; changes on a serial clock rise or on a start or abort release, so the bit
    // holds a full serial period unless a trigger releases the pin, and the host can latch it on the fall
    always_comb
    begin
        sdo_out_next = sdo_out_reg;
        sdo_oe_next = sdo_oe_reg;
        if (release_now)
        begin
            sdo_oe_next = 1'b0; // [R06] [R08]
            sdo_out_next = 1'b0;
        end
        else if (sck_in_frame)
        begin
            if (window_next)
            begin
                sdo_out_next = shift_reg[RESOLUTION-1]; // [R02] [R09] [R03]
                sdo_oe_next = 1'b1; // [R11] [R04]
            end
            else
            begin
                sdo_out_next = 1'b0;
                sdo_oe_next = 1'b0; // [R10] [R08]
            end
        end
    end

    // status next values; the mode decode is read from the controller so the
    // flags line up with its own mode flop
    wire busy_next = (state_next == adc_readout_pkg::FRAME_RUN)
                     && (edge_count_next < FRAME_END); // [R12]
    wire nap_next = (u_power.mode_next == adc_readout_pkg::MODE_NAP); // [R13]
    wire sleep_next = (u_power.mode_next == adc_readout_pkg::MODE_SLEEP); // [R14]
    wire missed_next = start && !word_taken;

    // serial clock history; reset low so a pin idling low gives no false rise
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            sck_prev_reg <= 1'b0;
        else
            sck_prev_reg <= sck;
    end

    // trigger history; a trigger held high through reset counts as one rise
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            trigger_prev_reg <= 1'b0;
        else
            trigger_prev_reg <= conversion_trigger;
    end

    // frame state
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            state_reg <= adc_readout_pkg::FRAME_IDLE;
        else
            state_reg <= state_next;
    end

    // edge count since the accepted trigger
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            edge_count_reg <= '0;
        else
            edge_count_reg <= edge_count_next; // [R11]
    end

    // word being shifted out
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            shift_reg <= '0;
        else
            shift_reg <= shift_next;
    end

    // serial data flop
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            sdo_out_reg <= 1'b0;
        else
            sdo_out_reg <= sdo_out_next;
    end

    // serial enable flop; released from reset without any host action
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            sdo_oe_reg <= 1'b0; // [R05]
        else
            sdo_oe_reg <= sdo_oe_next;
    end

    // busy from the accepted trigger until the frame unlocks
    // a host may use its fall as the earliest point for the next trigger
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            frame_busy_reg <= 1'b0;
        else
            frame_busy_reg <= busy_next;
    end

    // power status copies
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            nap_mode_reg <= 1'b0;
            sleep_mode_reg <= 1'b0;
        end
        else
        begin
            nap_mode_reg <= nap_next;
            sleep_mode_reg <= sleep_next;
        end
    end

    // one-cycle pulse when a frame starts on an empty buffer
    // the old shift contents go out in that frame, so the host must discard it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            word_missed_reg <= 1'b0;
        else
            word_missed_reg <= missed_next;
    end

    // ready lags the buffer by one cycle; a word offered as it fills is
    // simply not taken, so the sender keeps it offered until it goes in
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            sample_ready_reg <= 1'b0;
        else
            sample_ready_reg <= buffer_ready;
    end

    // port drive
    assign sdo_out = sdo_out_reg;
    assign sdo_oe = sdo_oe_reg;
    assign frame_busy = frame_busy_reg;
    assign nap_mode = nap_mode_reg;
    assign sleep_mode = sleep_mode_reg;
    assign word_missed = word_missed_reg;
    assign sample_ready = sample_ready_reg;

endmodule // sar_adc_serial_readout

// ===== hw/adc_readout_pkg.sv
// shared constants and types for the serial result readout
// assumes the serial clock and trigger pins are synchronous to clock
//
// What this block does
// [R01] every serial clock rising edge in a frame steps the conversion, and those in the data window move the output to its next bit.
// [R02] the first result bit, the most significant, goes out on the third serial clock rise after the trigger.
// [R03] the host latches each output bit on the falling edge of the serial clock.
// [R04] a 14-bit result sits right-justified in a 16-clock word and the host gives at least 16 clocks.
// [R05] at reset the serial output is released to high impedance with no host action.
// [R06] after reset the output stays released until a trigger rise starts a conversion.
// [R07] the result leaves the block in two's complement form.
// [R08] whenever no result bit is being sent the output stays released.
// [R09] a bit changed on one serial clock rise is stable before the next serial clock rise.
// [R10] resolution is a parameter and the output is released after the last result bit.
// [R11] a count of serial clock rises since the accepted trigger picks the bit and the enable.
// [R12] a trigger rise starts a conversion and later rises are ignored until 16 serial clock rises.
// [R13] two trigger rises with no serial clock rise between them put the device in nap.
// [R14] four trigger rises with no serial clock rise between them put the device in sleep.
// [R15] a serial clock rise wakes from nap or sleep and a conversion may then start at once.
package adc_readout_pkg;

    // resolution and frame shape
    localparam int RESOLUTION_DEFAULT = 14;
    localparam int FRAME_EDGES = 16;
    localparam int FIRST_BIT_EDGE = 3;
    localparam int EDGE_COUNT_W = 5;
    localparam logic [4:0] EDGE_COUNT_DONE = 5'h11;

    // power-down entry thresholds, in trigger rises without a serial clock rise
    localparam logic [2:0] NAP_TRIGGERS = 3'h2;
    localparam logic [2:0] SLEEP_TRIGGERS = 3'h4;

    // buffer between the converter core and the shifter
    localparam int BUFFER_DEPTH_DEFAULT = 2;

    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_NAP,
        MODE_SLEEP
    } power_mode_t;

    typedef enum logic {
        FRAME_IDLE,
        FRAME_RUN
    } frame_state_t;

endpackage

// ===== hw/sample_if.sv
// valid/ready carrier for converted words between buffer and shifter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface sample_if #(
    parameter int WIDTH = 14
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (
        output valid,
        output data,
        input ready
    );

    modport sink (
        input valid,
        input data,
        output ready
    );
endinterface

// ===== hw/result_buffer.sv
// small fifo holding finished conversion words
// assumes the filling side honours in_ready; drain side is the sample_if source
`timescale 1ns/1ps
module result_buffer #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    sample_if.source out
);
    localparam int PTR_W = (DEPTH > 2) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic full_reg;
    wire push = in_valid && !full_reg;
    wire pop = out.valid && out.ready;

    // pointer wrap shared by both ends
    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // occupancy; full is registered so the upstream ready comes from a flop
    assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
    assign in_ready = !full_reg;
    assign out.valid = (count_reg != '0);
    assign out.data = store[rd_ptr_reg];

    // storage write, no reset needed on the data array
    always_ff @(posedge clock)
    begin
        if (push)
            store[wr_ptr_reg] <= in_data;
    end

    // pointers and fill level
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            full_reg <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= bump(wr_ptr_reg);
            if (pop)
                rd_ptr_reg <= bump(rd_ptr_reg);
            count_reg <= count_next;
            full_reg <= (count_next == FULL_COUNT);
        end
    end
endmodule // result_buffer

// ===== hw/power_mode_ctrl.sv
// nap and sleep entry from trigger rises between serial clock rises
// assumes one-cycle rise pulses from the readout top
`timescale 1ns/1ps
module power_mode_ctrl (
    input wire logic clock,
    input wire logic nrst,
    input wire logic trigger_rise,
    input wire logic sck_rise,
    output adc_readout_pkg::power_mode_t mode,
    output logic [2:0] trigger_run
);
    adc_readout_pkg::power_mode_t mode_reg;
    adc_readout_pkg::power_mode_t mode_next;
    logic [2:0] run_reg;
    logic [2:0] run_next;
    wire [2:0] run_base = sck_rise ? 3'h0 : run_reg;

    // a serial clock rise clears the run; count saturates at the sleep threshold
    assign run_next = (trigger_rise && run_base != adc_readout_pkg::SLEEP_TRIGGERS)
                      ? run_base + 3'h1 : run_base;

    // mode decision; a wake and a trigger in one cycle count from zero
    always_comb
    begin
        mode_next = mode_reg;
        if (sck_rise)
            mode_next = adc_readout_pkg::MODE_ACTIVE; // [R15]
        if (run_next >= adc_readout_pkg::SLEEP_TRIGGERS)
            mode_next = adc_readout_pkg::MODE_SLEEP; // [R14]
        else if (run_next >= adc_readout_pkg::NAP_TRIGGERS && mode_next != adc_readout_pkg::MODE_SLEEP)
            mode_next = adc_readout_pkg::MODE_NAP; // [R13]
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_reg <= adc_readout_pkg::MODE_ACTIVE;
            run_reg <= 3'h0;
        end
        else
        begin
            mode_reg <= mode_next;
            run_reg <= run_next;
        end
    end

    assign mode = mode_reg;
    assign trigger_run = run_reg;
endmodule // power_mode_ctrl

// ===== verification/readout_sva.sv
// pin checks on the serial readout, bound to its top module
// assumes the block's one system clock and async active-low reset
`timescale 1ns/1ps
module readout_sva #(
    parameter int RESOLUTION = 14
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sck,
    input wire logic conversion_trigger,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic frame_busy,
    input wire logic nap_mode,
    input wire logic sleep_mode
);
    logic sck_q_reg;
    logic trig_q_reg;
    logic [2:0] run_reg;
    logic [2:0] run_next;
    wire logic sck_rise = sck && !sck_q_reg;
    wire logic trig_rise = conversion_trigger && !trig_q_reg;
    // trigger rises since the last serial clock rise, saturating
    assign run_next = sck_rise ? {2'h0, trig_rise}
        : run_reg + {2'h0, trig_rise && run_reg != 3'h7};
    // pin history, cleared with the block
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sck_q_reg <= 1'b0;
            trig_q_reg <= 1'b0;
            run_reg <= 3'h0;
        end
        else
        begin
            sck_q_reg <= sck;
            trig_q_reg <= conversion_trigger;
            run_reg <= run_next;
        end
    end
    logic [4:0] driven_reg;
    // serial clock rises seen while the pin is driven; the last one releases it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            driven_reg <= 5'h00;
        else if (!sdo_oe)
            driven_reg <= 5'h00;
        else if (sck_rise && driven_reg != 5'h1f)
            driven_reg <= driven_reg + 5'h01;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // fresh trigger into an idle, awake block
    sequence s_start;
        trig_rise && run_reg == 3'h0 && !frame_busy && !nap_mode && !sleep_mode;
    endsequence
    sequence s_second;
        trig_rise && !sck_rise && run_reg == 3'h1;
    endsequence
    sequence s_fourth;
        trig_rise && !sck_rise && run_reg == 3'h3;
    endsequence
    // one cycle of slack: pins may pass an input flop first
    a_released_low: assert property (sdo_oe || !sdo_out)
        else $error("sdo_out high while released");
    a_oe_on_rise: assert property ($rose(sdo_oe) |-> $past(sck_rise) || $past(sck_rise, 2))
        else $error("output enabled without a serial clock rise");
    a_oe_in_frame: assert property ($rose(sdo_oe) |-> frame_busy)
        else $error("output enabled outside a frame");
    a_bit_stands: assert property (sdo_oe && $past(sdo_oe) && !$past(sck_rise)
        && !$past(sck_rise, 2) |-> $stable(sdo_out))
        else $error("bit changed between serial clock rises");
    a_quiet_idle: assert property (!frame_busy && !sdo_oe |=> !sdo_oe)
        else $error("output driven while idle");
    a_trigger_starts: assert property (s_start |-> ##[1:2] frame_busy)
        else $error("trigger did not start a frame");
    a_nap_entry: assert property (s_second |-> ##[1:2] (nap_mode && !sdo_oe))
        else $error("second trigger did not nap");
    a_sleep_entry: assert property (s_fourth |-> ##[1:2] sleep_mode)
        else $error("fourth trigger did not sleep");
    a_wake_up: assert property (sck_rise |-> ##[1:2] (!nap_mode && !sleep_mode))
        else $error("serial clock did not wake");
    a_bit_count: assert property (driven_reg <= 5'(RESOLUTION))
        else $error("more bits driven than the resolution");
endmodule // readout_sva

// ===== verification/host_model.sv
// host model: makes serial clock and trigger, latches returned bits
// assumes pins move on the falling system clock edge, two clocks a serial clock level
`timescale 1ns/1ps
module host_model (
    input wire logic clock,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    output logic sck,
    output logic conversion_trigger
);
    logic [1:18] got;
    // released pin floats, so a stale bit can never pass as data
    wire logic sdo_pin = sdo_oe ? sdo_out : 1'bz;
    initial
    begin
        sck = 1'b0;
        conversion_trigger = 1'b0;
    end
    // one serial clock; the bit is latched as it falls
    task automatic pulse(output logic bit_got);
        @(negedge clock) sck = 1'b1;
        repeat (2) @(negedge clock);
        sck = 1'b0;
        bit_got = sdo_pin;
        @(negedge clock);
    endtask
    // trigger one clock high, then two low
    task automatic trig();
        @(negedge clock) conversion_trigger = 1'b1;
        @(negedge clock) conversion_trigger = 1'b0;
        @(negedge clock);
    endtask
    // 18 clocks a frame; a stray trigger after clock n if asked
    task automatic frame(input int retrig);
        trig();
        for (int n = 1; n <= 18; n++)
        begin
            pulse(got[n]);
            if (n == retrig)
                trig();
        end
    endtask
endmodule // host_model

// ===== verification/tb.sv
// self-checking bench: readout block, host model, pin checker
// assumes host_model and readout_sva are compiled before this file
`timescale 1ns/1ps
module tb;
    localparam int RES = 14;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic sample_valid = 1'b0;
    logic [RES-1:0] sample_data = 14'h0000;
    logic [17:0] missed = 18'h00000;
    wire logic sck, conversion_trigger, sample_ready, sdo_out, sdo_oe;
    wire logic frame_busy, nap_mode, sleep_mode, word_missed;
    int fails = 0;
    int checks = 0;
    // 50 MHz system clock
    always #10 clock = ~clock;
    // underrun pulses, sampled mid-cycle where the flop output has settled
    always @(negedge clock)
        if (word_missed === 1'b1)
            missed <= missed + 18'h00001;
    sar_adc_serial_readout #(.RESOLUTION(RES)) u_sar_adc_serial_readout (
        .clock(clock), .nrst(nrst), .sck(sck), .conversion_trigger(conversion_trigger),
        .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .frame_busy(frame_busy), .nap_mode(nap_mode),
        .sleep_mode(sleep_mode), .word_missed(word_missed));
    host_model u_host_model (.clock(clock), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sck(sck),
        .conversion_trigger(conversion_trigger));
    task automatic check(input logic [17:0] got, input logic [17:0] want, input string what);
        checks++;
        if (got !== want)
        begin
            fails++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // offer one word; only called while the buffer has room
    task automatic push(input logic [RES-1:0] d);
        int i;
        for (i = 0; i < 50 && sample_ready !== 1'b1; i++)
            @(negedge clock);
        if (i == 50)
        begin
            fails++;
            stop_test();
        end
        @(negedge clock);
        sample_valid = 1'b1;
        sample_data = d;
        @(negedge clock) sample_valid = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    // one frame; word expected msb first, sign flipped, released around it
    task automatic run(input logic [RES-1:0] d, input int retrig, input string what);
        u_host_model.frame(retrig);
        check(u_host_model.got, {2'bzz, ~d[RES-1], d[RES-2:0], 2'bzz}, what);
    endtask
    task automatic t_reset();
        logic [2:0] b;
        check({13'h0000, sdo_oe, frame_busy, nap_mode, sleep_mode, sample_ready},
            18'h00001, "rst");
        for (int n = 0; n < 3; n++)
            u_host_model.pulse(b[n]);
        check({15'h0000, b}, {15'h0000, 3'bzzz}, "idle clocks");
        $display("test reset done");
    endtask
    task automatic t_frames();
        logic [RES-1:0] w [4] = '{14'h3fff, 14'h0000, 14'h2000, 14'h1555};
        foreach (w[i])
        begin
            push(w[i]);
            run(w[i], 0, "frame");
        end
        push(14'h2a5a);
        run(14'h2a5a, 8, "stray trigger");
        $display("test frames done");
    endtask
    // fill, offer a third word held through a stall, drain in order
    task automatic t_buffer();
        push(14'h0111);
        push(14'h3222);
        repeat (2) @(negedge clock);
        check({17'h00000, sample_ready}, 18'h00000, "full");
        sample_valid = 1'b1;
        sample_data = 14'h1333;
        run(14'h0111, 0, "first");
        sample_valid = 1'b0;
        run(14'h3222, 0, "second");
        run(14'h1333, 0, "third");
        $display("test buffer done");
    endtask
    task automatic t_power();
        logic b;
        u_host_model.trig();
        u_host_model.trig();
        check({16'h0000, sdo_oe, nap_mode}, 18'h00001, "nap");
        u_host_model.trig();
        u_host_model.trig();
        check({17'h00000, sleep_mode}, 18'h00001, "sleep");
        u_host_model.pulse(b);
        check({16'h0000, nap_mode, sleep_mode}, 18'h00000, "wake");
        push(14'h0abc);
        run(14'h0abc, 0, "after wake");
        check(missed, 18'h00001, "underruns");
        $display("test power done");
    endtask
    initial
    begin
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        repeat (2) @(negedge clock);
        t_reset();
        t_frames();
        t_buffer();
        t_power();
        stop_test();
    end
    // hang guard, far beyond the whole sequence
    initial
    begin
        repeat (8000) @(posedge clock);
        fails++;
        $display("BAD %0t run timed out", $time);
        stop_test();
    end
endmodule // tb
bind sar_adc_serial_readout readout_sva #(.RESOLUTION(RESOLUTION)) u_readout_sva (
    .clock(clock), .nrst(nrst), .sck(sck), .conversion_trigger(conversion_trigger),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .frame_busy(frame_busy), .nap_mode(nap_mode),
    .sleep_mode(sleep_mode));
